// file: hw/pbwake_params.svh
`ifndef PBWAKE_PARAMS_SVH
`define PBWAKE_PARAMS_SVH

// Clock rate in kHz and derived pulse lengths.
`define CLK_KHZ            25000
`define INT_PULSE_US       128
`define INT_PULSE_CYC      ((`INT_PULSE_US * `CLK_KHZ) / 1000)
// Reset output pulse duration in microseconds.
`define RESET_PULSE_US     400000
// Divided first: the product of the two figures would overflow 32-bit arithmetic.
`define RESET_PULSE_CYC    ((`RESET_PULSE_US / 1000) * `CLK_KHZ)
// Wake hold thresholds in milliseconds, selected by a two-bit field.
`define WAKE_MS_0          80
`define WAKE_MS_1          1000
`define WAKE_MS_2          2000
`define WAKE_MS_3          4000
// Reset hold thresholds in milliseconds, selected by a two-bit field.
`define RESET_MS_0         5000
`define RESET_MS_1         9000
`define RESET_MS_2         11000
`define RESET_MS_3         15000
// Width of the hold time counter and of the pulse counters.
`define HOLD_CNT_W         32
`define PULSE_CNT_W        24

`endif

// file: hw/pbwake_pkg.sv
package pbwake_pkg;

	// Supply and enable conditions seen by the supervisor.
	typedef struct packed {
		logic battery_node_ok;
		logic input_supply_ok;
		logic charge_en;
	} supply_type;

	// Recovery destinations after a reset.
	typedef enum logic [1:0] {
		REC_RESUME = 2'b00,
		REC_SHIP   = 2'b01,
		REC_HIZ    = 2'b10
	} recovery_type;

	// Button supervisor states.
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_HOLD    = 2'b01,
		ST_RESET   = 2'b10,
		ST_WAIT_HI = 2'b11
	} pb_state_type;

endpackage

// file: hw/pulse_gen.sv
`timescale 1ns/1ps
`include "pbwake_params.svh"

// One-shot pulse generator: a trigger starts a fixed-length pulse.
module pulse_gen #(
	parameter logic [`PULSE_CNT_W-1:0] LEN = 24'h000001
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic trig,
	output logic      active
);
	logic [`PULSE_CNT_W-1:0] cnt_r;
	logic [`PULSE_CNT_W-1:0] cnt_nxt;

	// A new trigger restarts the count; zero means idle.
	always_comb begin
		cnt_nxt = cnt_r;
		if (trig)
			cnt_nxt = LEN;
		else if (cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
	end

	// Register the count.
	always_ff @(posedge clk) begin
		if (rst)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign active = (cnt_r != '0);
endmodule // pulse_gen

// file: hw/pbwake.sv
// Operation
// RL1: Button acts only with battery present, or supply valid and charging enabled.
// RL2: Host side should not press button while supply ramps up.
// RL3: Wake and reset hold times come from separate select fields.
// RL4: Wake condition gives one interrupt pulse and sets wake flags.
// RL5: Wake and reset flags hold until the control register is read.
// RL6: Reset condition gives interrupt pulse and asserts active-low reset.
// RL7: Exactly one fixed-length reset pulse per reset condition.
// RL8: No new reset until release and new hold for wake time.
// RL9: Battery-only reset enters ship or high-impedance per recovery select.
// RL10: Reset with valid supply returns to prior operating state.
// RL11: Disabled system rail is re-enabled when recovering to high-impedance or battery.
// RL12: Config bit chooses button-only or button plus valid supply reset.
// RL13: Disabled rail re-enables only on supply connect or reset-length hold.
// RL14: Any fault sends an interrupt pulse.
// RL15: Low time counted, restarted on release, compared with thresholds.
`timescale 1ns/1ps
`include "pbwake_params.svh"

module pbwake
	import pbwake_pkg::*;
#(
	parameter int unsigned WAKE_MS0   = `WAKE_MS_0,
	parameter int unsigned WAKE_MS1   = `WAKE_MS_1,
	parameter int unsigned WAKE_MS2   = `WAKE_MS_2,
	parameter int unsigned WAKE_MS3   = `WAKE_MS_3,
	parameter int unsigned RESET_MS0  = `RESET_MS_0,
	parameter int unsigned RESET_MS1  = `RESET_MS_1,
	parameter int unsigned RESET_MS2  = `RESET_MS_2,
	parameter int unsigned RESET_MS3  = `RESET_MS_3,
	parameter int unsigned RESET_CYC  = `RESET_PULSE_CYC,
	parameter int unsigned CYC_PER_MS = `CLK_KHZ
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 manual_button_n,
	input  wire pbwake_pkg::supply_type supply,
	input  wire logic [1:0]           button_wake_time_sel,
	input  wire logic [1:0]           button_reset_time_sel,
	input  wire logic                 button_recovery_sel,
	input  wire logic                 reset_needs_supply_sel,
	input  wire logic                 control_reg_read,
	input  wire logic                 fault_event,
	input  wire logic                 rail_disable_req,
	output logic                      int_n,
	output logic                      reset_out_n,
	output logic [1:0]                button_wake_flags,
	output logic                      reset_flag,
	output logic                      system_rail_en,
	output pbwake_pkg::recovery_type  recovery_mode
);
	import pbwake_pkg::*;

	// Converts milliseconds to a clock count of the hold counter width.
	function automatic logic [`HOLD_CNT_W-1:0] ms_cyc(input int unsigned ms);
		longint unsigned c;
		c = longint'(ms) * longint'(CYC_PER_MS);
		return c[`HOLD_CNT_W-1:0];
	endfunction

	pb_state_type            st_r, st_nxt;
	logic [`HOLD_CNT_W-1:0]  hold_r, hold_nxt;
	logic [1:0]              wflag_r, wflag_nxt;
	logic                    rflag_r, rflag_nxt;
	logic                    rail_r, rail_nxt;
	recovery_type            rec_r, rec_nxt;
	logic                    int_trig, rst_trig;
	logic                    int_act, rst_act;
	logic                    int_n_r, rst_n_r;
	logic                    enabled, sup_ok, wake_hit, reset_hit, reset_allowed;
	logic [`HOLD_CNT_W-1:0]  wake_thr, reset_thr;

	// Button qualification and threshold selection.
	always_comb begin
		enabled = supply.battery_node_ok |
			(supply.input_supply_ok & supply.charge_en); // RL1
		sup_ok = supply.input_supply_ok;
		case (button_wake_time_sel) // RL3
			2'h0:    wake_thr = ms_cyc(WAKE_MS0);
			2'h1:    wake_thr = ms_cyc(WAKE_MS1);
			2'h2:    wake_thr = ms_cyc(WAKE_MS2);
			default: wake_thr = ms_cyc(WAKE_MS3);
		endcase
		case (button_reset_time_sel) // RL3
			2'h0:    reset_thr = ms_cyc(RESET_MS0);
			2'h1:    reset_thr = ms_cyc(RESET_MS1);
			2'h2:    reset_thr = ms_cyc(RESET_MS2);
			default: reset_thr = ms_cyc(RESET_MS3);
		endcase
		wake_hit  = (hold_r == wake_thr); // RL15
		reset_hit = (hold_r == reset_thr); // RL15
		reset_allowed = !reset_needs_supply_sel | sup_ok; // RL12
	end

	// Button state machine, hold counter, flags and recovery.
	always_comb begin
		st_nxt    = st_r;
		hold_nxt  = hold_r;
		wflag_nxt = wflag_r;
		rflag_nxt = rflag_r;
		rail_nxt  = rail_r;
		rec_nxt   = rec_r;
		int_trig  = 1'b0;
		rst_trig  = 1'b0;
		// A read clears the flags; a same-cycle event sets them again below.
		if (control_reg_read) begin // RL5
			wflag_nxt = 2'b00;
			rflag_nxt = 1'b0;
		end
		if (fault_event)
			int_trig = 1'b1; // RL14
		if (rail_disable_req)
			rail_nxt = 1'b0;
		if (sup_ok && !rail_r)
			rail_nxt = 1'b1; // RL13
		case (st_r)
			ST_IDLE: begin
				hold_nxt = '0;
				if (!manual_button_n && enabled)
					st_nxt = ST_HOLD;
			end
			ST_HOLD: begin
				if (manual_button_n || !enabled) begin
					hold_nxt = '0; // RL15
					st_nxt = ST_IDLE;
				end else begin
					if (hold_r != '1)
						hold_nxt = hold_r + 1'b1; // RL15
					if (wake_hit) begin
						int_trig = 1'b1; // RL4
						wflag_nxt[0] = 1'b1; // RL4
						if (hold_r >= ms_cyc(WAKE_MS1))
							wflag_nxt[1] = 1'b1; // RL4
					end
					if (reset_hit && reset_allowed) begin
						int_trig  = 1'b1; // RL6
						rst_trig  = 1'b1; // RL6
						rflag_nxt = 1'b1;
						st_nxt    = ST_RESET;
						if (sup_ok)
							rec_nxt = REC_RESUME; // RL10
						else if (button_recovery_sel)
							rec_nxt = REC_HIZ; // RL9
						else
							rec_nxt = REC_SHIP; // RL9
						if (sup_ok || button_recovery_sel)
							rail_nxt = 1'b1; // RL11 RL13
					end
				end
			end
			ST_RESET: begin
				st_nxt = ST_WAIT_HI; // RL7
			end
			ST_WAIT_HI: begin
				hold_nxt = '0;
				if (manual_button_n)
					st_nxt = ST_IDLE; // RL8
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r    <= ST_IDLE;
			hold_r  <= '0;
			wflag_r <= 2'b00;
			rflag_r <= 1'b0;
			rail_r  <= 1'b1;
			rec_r   <= REC_RESUME;
		end else begin
			st_r    <= st_nxt;
			hold_r  <= hold_nxt;
			wflag_r <= wflag_nxt;
			rflag_r <= rflag_nxt;
			rail_r  <= rail_nxt;
			rec_r   <= rec_nxt;
		end
	end

	// Interrupt pulse of fixed length.
	pulse_gen #(.LEN(`PULSE_CNT_W'(`INT_PULSE_CYC))) u_int_pulse (
		.clk    (clk),
		.rst    (rst),
		.trig   (int_trig),
		.active (int_act)
	);

	// Reset pulse of fixed length.
	pulse_gen #(.LEN(`PULSE_CNT_W'(RESET_CYC))) u_rst_pulse (
		.clk    (clk),
		.rst    (rst),
		.trig   (rst_trig),
		.active (rst_act)
	);

	// Output flops.
	always_ff @(posedge clk) begin
		if (rst) begin
			int_n_r <= 1'b1;
			rst_n_r <= 1'b1;
		end else begin
			int_n_r <= !int_act;
			rst_n_r <= !rst_act; // RL7
		end
	end

	assign int_n             = int_n_r;
	assign reset_out_n       = rst_n_r;
	assign button_wake_flags = wflag_r;
	assign reset_flag        = rflag_r;
	assign system_rail_en    = rail_r;
	assign recovery_mode     = rec_r;

	// Checker state: the length so far of the low pulse on each active-low output, and
	// whether the button has been seen high since the last reset trigger. The counters
	// saturate, so a pin stuck low cannot wrap round and look like a fresh short pulse.
	logic [`PULSE_CNT_W-1:0] int_low_r, int_low_nxt;
	logic [`PULSE_CNT_W-1:0] rst_low_r, rst_low_nxt;
	logic                    seen_rel_r, seen_rel_nxt;

	// Next values of the checker state.
	always_comb begin
		int_low_nxt  = '0;
		rst_low_nxt  = '0;
		seen_rel_nxt = seen_rel_r;
		if (!int_n_r)
			int_low_nxt = (int_low_r == '1) ? int_low_r : int_low_r + 1'b1;
		if (!rst_n_r)
			rst_low_nxt = (rst_low_r == '1) ? rst_low_r : rst_low_r + 1'b1;
		if (manual_button_n)
			seen_rel_nxt = 1'b1;
		if (rst_trig)
			seen_rel_nxt = 1'b0;
	end

	// Register the checker state; the button counts as released out of reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			int_low_r  <= '0;
			rst_low_r  <= '0;
			seen_rel_r <= 1'b1;
		end else begin
			int_low_r  <= int_low_nxt;
			rst_low_r  <= rst_low_nxt;
			seen_rel_r <= seen_rel_nxt;
		end
	end

	// Reset and interrupt both go low two cycles after the trigger: one cycle to load the
	// pulse counter, one for the output flop.
	a_reset_start: assert property (@(posedge clk) disable iff (rst) // RL6
		rst_trig |-> ##2 (!reset_out_n && !int_n))
		else $error("reset pulse missing");

	// A wake hit sets the first flag next cycle and pulls the interrupt low the cycle after.
	a_wake_int: assert property (@(posedge clk) disable iff (rst) // RL4
		(st_r == ST_HOLD && wake_hit && !manual_button_n && enabled)
		|-> ##1 button_wake_flags[0] ##1 !int_n)
		else $error("wake not signalled");

	// A read with no event in flight leaves every flag clear.
	a_flag_clear: assert property (@(posedge clk) disable iff (rst) // RL5
		(control_reg_read && !int_trig && !(st_r == ST_HOLD))
		|=> (button_wake_flags == 2'b00 && !reset_flag))
		else $error("flags not cleared");

	// One reset per press: the machine leaves the reset state at once, and a new trigger
	// needs a release first and then a hold of at least the wake time.
	a_one_reset: assert property (@(posedge clk) disable iff (rst) // RL7
		(st_r == ST_RESET) |=> (st_r == ST_WAIT_HI))
		else $error("reset not single");
	a_no_rereset: assert property (@(posedge clk) disable iff (rst) // RL8
		rst_trig |-> seen_rel_r)
		else $error("reset repeated without release");
	a_rereset_hold: assert property (@(posedge clk) disable iff (rst) // RL8
		rst_trig |-> (hold_r >= wake_thr))
		else $error("reset before wake time");

	// The reset pulse has its fixed length. A fault during an interrupt pulse restarts it,
	// so an interrupt pulse is checked for its minimum length only.
	a_reset_length: assert property (@(posedge clk) disable iff (rst) // RL7
		$rose(reset_out_n) |-> (rst_low_r == `PULSE_CNT_W'(RESET_CYC)))
		else $error("reset pulse length wrong");
	a_int_length: assert property (@(posedge clk) disable iff (rst) // RL4 RL14
		$rose(int_n) |-> (int_low_r >= `PULSE_CNT_W'(`INT_PULSE_CYC)))
		else $error("interrupt pulse too short");

	// The button is ignored while not enabled, and reset may be gated by the supply.
	a_gate_off: assert property (@(posedge clk) disable iff (rst) // RL1
		(!enabled && st_r == ST_IDLE) |=> (st_r == ST_IDLE))
		else $error("button used while off");
	a_need_sup: assert property (@(posedge clk) disable iff (rst) // RL12
		(rst_trig && reset_needs_supply_sel) |-> sup_ok)
		else $error("reset without supply");
	a_fault_int: assert property (@(posedge clk) disable iff (rst) // RL14
		fault_event |-> ##2 !int_n)
		else $error("fault interrupt missing");

	// The recovery destination follows the supply and the recovery select.
	a_ship_rec: assert property (@(posedge clk) disable iff (rst) // RL9
		(rst_trig && !sup_ok && !button_recovery_sel) |=> (recovery_mode == REC_SHIP))
		else $error("wrong recovery");
	a_hiz_rec: assert property (@(posedge clk) disable iff (rst) // RL9
		(rst_trig && !sup_ok && button_recovery_sel) |=> (recovery_mode == REC_HIZ))
		else $error("high-impedance recovery missing");
	a_resume_rec: assert property (@(posedge clk) disable iff (rst) // RL10
		(rst_trig && sup_ok) |=> (recovery_mode == REC_RESUME))
		else $error("resume recovery missing");

	// The rail comes back with a supply or after a reset into high impedance or battery
	// operation, and otherwise stays off once disabled.
	a_rail_recover: assert property (@(posedge clk) disable iff (rst) // RL11
		(rst_trig && (sup_ok || button_recovery_sel)) |=> system_rail_en)
		else $error("rail not re-enabled after reset");
	a_rail_supply: assert property (@(posedge clk) disable iff (rst) // RL13
		(sup_ok && !system_rail_en) |=> system_rail_en)
		else $error("rail not re-enabled by supply");
	a_rail_held: assert property (@(posedge clk) disable iff (rst) // RL13
		(!system_rail_en && !sup_ok && !rst_trig) |=> !system_rail_en)
		else $error("rail re-enabled without cause");

	// A release or a loss of enable restarts the hold count from zero.
	a_hold_restart: assert property (@(posedge clk) disable iff (rst) // RL15
		(st_r == ST_HOLD && (manual_button_n || !enabled))
		|=> (st_r == ST_IDLE && hold_r == '0))
		else $error("hold count not restarted");
endmodule // pbwake

// file: bench/button_host_model.sv
`timescale 1ns/1ps

// Stands in for the user's push-button and the host's reads of the control register.
module button_host_model (
	input  wire logic clk,
	output logic      manual_button_n,
	output logic      control_reg_read
);
	// The internal pull-up holds the released button line high.
	initial begin
		manual_button_n  = 1'b1;
		control_reg_read = 1'b0;
	end

	// Holds the button low for a number of cycles; the bench keeps supply steady meanwhile.
	task automatic press(input logic [31:0] cyc);
		@(posedge clk);
		manual_button_n <= 1'b0;
		repeat (cyc) @(posedge clk);
		manual_button_n <= 1'b1;
	endtask

	// A host read of the control register lasts one cycle.
	task automatic host_read();
		@(posedge clk);
		control_reg_read <= 1'b1;
		@(posedge clk);
		control_reg_read <= 1'b0;
	endtask
endmodule // button_host_model

// file: bench/test_pbwake.sv
`timescale 1ns/1ps

module test_pbwake;
	import pbwake_pkg::*;
	logic         clk      = 1'b0;
	logic         rst      = 1'b1;
	logic         fault    = 1'b0;
	logic         rail_off = 1'b0;
	logic         rec_sel  = 1'b1;
	logic         need_sup = 1'b0;
	logic [1:0]   wsel     = 2'h0;
	logic [1:0]   rsel     = 2'h0;
	supply_type   supply   = 3'h4;
	logic         btn_n, rd, int_n, rst_n, rflag, rail_en, int_d, rs_d;
	logic [1:0]   flags;
	recovery_type rec;
	logic [31:0]  fail_count = 0, comparisons = 0, cycles = 0;
	logic [31:0]  int_falls = 0, int_len = 0, rs_falls = 0, rs_len = 0;

	button_host_model m (.clk(clk), .manual_button_n(btn_n), .control_reg_read(rd));

	// Thresholds keep their millisecond values, counted at one cycle per millisecond.
	pbwake #(.RESET_CYC(10), .CYC_PER_MS(1)) dut (.clk(clk), .rst(rst), .manual_button_n(btn_n),
		.supply(supply), .button_wake_time_sel(wsel), .button_reset_time_sel(rsel),
		.button_recovery_sel(rec_sel), .reset_needs_supply_sel(need_sup),
		.control_reg_read(rd), .fault_event(fault), .rail_disable_req(rail_off),
		.int_n(int_n), .reset_out_n(rst_n), .button_wake_flags(flags),
		.reset_flag(rflag), .system_rail_en(rail_en), .recovery_mode(rec));

	always #20 clk = ~clk;

	// Counts low pulses on both active-low outputs and their lengths; cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		int_d <= int_n;
		rs_d <= rst_n;
		if (int_n === 1'b0) int_len <= (int_d === 1'b1) ? 1 : int_len + 1;
		if (int_n === 1'b0 && int_d === 1'b1) int_falls <= int_falls + 1;
		if (rst_n === 1'b0) rs_len <= (rs_d === 1'b1) ? 1 : rs_len + 1;
		if (rst_n === 1'b0 && rs_d === 1'b1) rs_falls <= rs_falls + 1;
		if (cycles == 80000) begin
			fail_count = fail_count + 1;
			results();
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("FAIL %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// Lets any interrupt pulse run out before the next check.
	task automatic settle();
		repeat (3400) @(posedge clk);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence of button and host scenarios.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk("reset_out_n", 1, rst_n);
		chk("rail_en", 1, rail_en);
		m.press(100);
		settle();
		chk("flags", 2'b01, flags);
		chk("int_falls", 1, int_falls);
		chk("int_len", 3200, int_len);
		m.host_read();
		repeat (2) @(posedge clk);
		chk("flags", 0, flags);
		// A fault alone gives one full interrupt pulse.
		fault <= 1'b1;
		@(posedge clk);
		fault <= 1'b0;
		settle();
		chk("int_falls", 2, int_falls);
		chk("int_len", 3200, int_len);
		// Battery-only reset with the rail disabled beforehand; the hold runs past twice
		// the reset time, and still only one reset pulse may come out.
		rail_off <= 1'b1;
		@(posedge clk);
		rail_off <= 1'b0;
		repeat (3) @(posedge clk);
		chk("rail_en", 0, rail_en);
		m.press(10010);
		settle();
		chk("rs_falls", 1, rs_falls);
		chk("rs_len", 10, rs_len);
		chk("int_falls", 4, int_falls);
		chk("reset_flag", 1, rflag);
		chk("recovery", REC_HIZ, rec);
		chk("rail_en", 1, rail_en);
		m.host_read();
		repeat (2) @(posedge clk);
		chk("reset_flag", 0, rflag);
		// Reset that needs a valid supply is refused on battery only.
		need_sup <= 1'b1;
		m.press(5010);
		settle();
		chk("rs_falls", 1, rs_falls);
		chk("reset_flag", 0, rflag);
		supply <= 3'h7;
		m.press(5010);
		settle();
		chk("rs_falls", 2, rs_falls);
		chk("recovery", REC_RESUME, rec);
		m.host_read();
		// With no battery and no supply the button is ignored.
		supply <= 3'h0;
		need_sup <= 1'b0;
		m.press(100);
		settle();
		chk("flags", 0, flags);
		// Two short holds do not add up; a longer one reaches the 1000 ms wake setting.
		supply <= 3'h4;
		wsel <= 2'h1;
		m.press(600);
		m.press(600);
		repeat (5) @(posedge clk);
		chk("wake0", 0, flags[0]);
		m.press(1010);
		repeat (5) @(posedge clk);
		chk("flags", 2'b11, flags);
		// Battery-only reset into ship mode at the 9000 ms setting leaves the rail off.
		m.host_read();
		rail_off <= 1'b1;
		rec_sel <= 1'b0;
		rsel <= 2'h1;
		@(posedge clk);
		rail_off <= 1'b0;
		m.press(5010);
		settle();
		chk("rs_falls", 2, rs_falls);
		m.press(9010);
		settle();
		chk("rs_falls", 3, rs_falls);
		chk("rs_len", 10, rs_len);
		chk("recovery", REC_SHIP, rec);
		chk("rail_en", 0, rail_en);
		results();
	end
endmodule // test_pbwake
